// *** src/anid_regs.sv ***
// Identifier, advertisement and partner ability registers of one port,
// with a minimal control and status word, behind the serial management port.
// Assumes the arbitration logic shares sys_clk and hands over received pages.
`timescale 1ns/10ps

// How it works
// - Upper identifier holds OUI bits 21:6
// - Lower identifier: OUI 5:0, model, revision
// - OUI bits 23:22 never appear
// - Identifiers at 2 and 3, read-only
// - Advertise bit 15 next-page, resets 0
// - Advertise bit 13 remote fault, resets 0
// - Pause bit informational only, resets 0
// - Bits 9:5 select advertised technologies
// - Reset sets bits 7 and 5 only
// - Selector field fixed at 00001
// - Partner bit 15 shows next-page request
// - Partner bit 14 shows partner acknowledge
// - Partner bit 13 copies remote fault
// - Partner bit 10 shows partner pause
// - Partner 9:5 cleared on restart, reset
// - Partner selector cleared on restart, reset
// - Status bit 5 set after completion only
// - Control bit 9 restarts, reads 0
module anid_regs
   import anid_pkg::*;
#(
   parameter logic [23:0] OUI = 24'h5A3C96,    // Arbitrary value
   parameter logic [5:0] MODEL = 6'h2B,        // Arbitrary value
   parameter logic [3:0] REVISION = 4'h6       // Arbitrary value
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] phy_addr,
   input wire logic an_hw_en,
   input wire logic an_complete,
   input wire logic lp_page_stb,
   input wire logic [15:0] lp_page_word,
   output logic [15:0] adv_tx_word,
   output logic an_restart
);

   logic [4:0] reg_addr;
   logic [15:0] wr_data;
   logic wr_stb;
   logic [15:0] rd_data;

   logic hw_en_s1, hw_en_s2;
   logic an_en_r;
   logic adv_np_r;
   logic adv_rf_r;
   logic adv_pause_r;
   logic [4:0] adv_tech_r;
   logic [15:0] lp_ability_r;
   logic lp_loaded_r;

   logic wr_ctrl, wr_adv;
   logic restart_go;
   logic an_done_w;
   logic [15:0] ident_upper;
   logic [15:0] ident_lower;
   logic [15:0] ctrl_rd;
   logic [15:0] stat_rd;
   logic [15:0] adv_rd;

   // Serial management frame engine
   anid_mdio_ser u_ser (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .mdc(mdc),
      .mdio_in(mdio_in),
      .phy_addr(phy_addr),
      .rd_data(rd_data),
      .reg_addr(reg_addr),
      .wr_data(wr_data),
      .wr_stb(wr_stb),
      .mdio_out(mdio_out),
      .mdio_oe(mdio_oe)
   );

   // Hardware enable pin synchroniser
   always_ff @(posedge sys_clk) begin
      hw_en_s1 <= an_hw_en;
      hw_en_s2 <= hw_en_s1;
   end

   // Write decode
   assign wr_ctrl = wr_stb && (reg_addr == REG_CTRL);
   assign wr_adv = wr_stb && (reg_addr == REG_ADV);

   // Restart only while negotiation is enabled
   assign restart_go = wr_ctrl && wr_data[CTRL_RESTART_BIT] && an_en_r && hw_en_s2;

   // Identifier constants, top two OUI bits dropped
   assign ident_upper = OUI[21:6];
   assign ident_lower = {OUI[5:0], MODEL, REVISION};

   // Completion shown only once a page is in place
   assign an_done_w = an_complete && lp_loaded_r;

   // Read words of control, status and advertisement
   assign ctrl_rd = {3'h0, an_en_r, 12'h000};
   assign stat_rd = STAT_FIXED | {10'h000, an_done_w, 5'h00};
   assign adv_rd = {adv_np_r, 1'b0, adv_rf_r, 2'h0, adv_pause_r, adv_tech_r, ADV_SEL};

   // Read mux; unmapped addresses read zero, writes to 2 and 3 ignored
   assign rd_data = (reg_addr == REG_CTRL) ? ctrl_rd :
                    (reg_addr == REG_STAT) ? stat_rd :
                    (reg_addr == REG_ID_UP) ? ident_upper :
                    (reg_addr == REG_ID_LO) ? ident_lower :
                    (reg_addr == REG_ADV) ? adv_rd :
                    (reg_addr == REG_LP) ? lp_ability_r :
                    16'h0000;

   // Software enable; a write is ignored while the pin disables it
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         an_en_r <= CTRL_AN_EN_RST;
      end else if (wr_ctrl && hw_en_s2) begin
         an_en_r <= wr_data[CTRL_AN_EN_BIT];
      end
   end

   // Advertisement fields
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         adv_np_r <= 1'b0;
         adv_rf_r <= 1'b0;
         adv_pause_r <= 1'b0;
         adv_tech_r <= ADV_TECH_RST;
      end else if (wr_adv) begin
         adv_np_r <= wr_data[ADV_NP_BIT];
         adv_rf_r <= wr_data[ADV_RF_BIT];
         adv_pause_r <= wr_data[ADV_PAUSE_BIT];
         adv_tech_r <= wr_data[ADV_TECH_HI:ADV_TECH_LO];
      end
   end

   // Word handed to the arbitration logic; pause is passed on only
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         adv_tx_word <= {6'h00, ADV_TECH_RST, ADV_SEL};
      end else begin
         adv_tx_word <= adv_rd;
      end
   end

   // Restart pulse to the arbitration logic
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         an_restart <= 1'b0;
      end else begin
         an_restart <= restart_go;
      end
   end

   // Partner page: whole word in one update, restart clears it
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         lp_ability_r <= LP_RST;
      end else if (restart_go) begin
         lp_ability_r <= LP_RST;
      end else if (lp_page_stb) begin
         lp_ability_r <= lp_page_word;
      end
   end

   // Page present since the last restart
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         lp_loaded_r <= 1'b0;
      end else if (restart_go) begin
         lp_loaded_r <= 1'b0;
      end else if (lp_page_stb) begin
         lp_loaded_r <= 1'b1;
      end
   end

   // Checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_restart_req;
      wr_ctrl && wr_data[CTRL_RESTART_BIT] && an_en_r && hw_en_s2;
   endsequence

   sequence s_restart_pulse;
      an_restart ##1 !an_restart;
   endsequence

   sequence s_page_in;
      lp_page_stb && !restart_go;
   endsequence

   sequence s_page_settle;
      s_page_in ##1 (!lp_page_stb && !restart_go);
   endsequence

   // Upper identifier value
   chk_ident_upper_val: assert property (
      (reg_addr == REG_ID_UP) |-> (rd_data == OUI[21:6]))
      else $error("upper identifier read wrong");

   // Lower identifier value
   chk_ident_lower_val: assert property (
      (reg_addr == REG_ID_LO) |-> (rd_data == {OUI[5:0], MODEL, REVISION}))
      else $error("lower identifier read wrong");

   // Both words together carry exactly OUI bits 21:0
   chk_ident_oui_span: assert property (
      {ident_upper, ident_lower[15:10]} == OUI[21:0])
      else $error("identifier carries wrong OUI bits");

   // Writes to identifiers leave reads unchanged
   chk_ident_ro_write: assert property (
      (wr_stb && (reg_addr == REG_ID_UP || reg_addr == REG_ID_LO))
      |=> $stable(ident_upper) && $stable(ident_lower) && $stable(adv_rd))
      else $error("identifier write had an effect");

   // Advertisement write lands in next-page and fault bits
   chk_adv_np_write: assert property (
      wr_adv |=> (adv_np_r == $past(wr_data[ADV_NP_BIT]))
      && (adv_rf_r == $past(wr_data[ADV_RF_BIT])))
      else $error("advertise write not stored");

   // Reset values of the advertisement word
   chk_adv_reset_val: assert property (
      disable iff (1'b0)
      !resetn |=> (adv_rd == {6'h00, ADV_TECH_RST, ADV_SEL}))
      else $error("advertise reset value wrong");

   // Outgoing word follows the register one cycle later
   chk_adv_tx_follow: assert property (
      ##1 (adv_tx_word[15:5] == $past(adv_rd[15:5])))
      else $error("outgoing word lags wrongly");

   // Selector always 00001, reserved bits zero
   chk_adv_selector: assert property (
      (adv_tx_word[4:0] == ADV_SEL) && (adv_rd[14] == 1'b0) && (adv_rd[12:11] == 2'h0))
      else $error("selector or reserved bits wrong");

   // Received page loads whole
   chk_lp_page_load: assert property (
      s_page_in |=> (lp_ability_r == $past(lp_page_word)) && lp_loaded_r)
      else $error("partner page not loaded");

   // Restart clears partner technologies and selector
   chk_lp_restart_clr: assert property (
      an_restart |-> (lp_ability_r[9:0] == 10'h000) && !lp_loaded_r)
      else $error("partner word not cleared on restart");

   // Partner word holds between pages and restarts
   chk_lp_hold: assert property (
      !lp_page_stb && !restart_go |=> $stable(lp_ability_r))
      else $error("partner word changed without cause");

   // Completion bit needs a page and the completion level
   chk_stat_done: assert property (
      (reg_addr == REG_STAT) && rd_data[STAT_DONE_BIT] |-> an_complete && lp_loaded_r)
      else $error("completion shown too early");

   // Restart request gives a one-cycle pulse
   chk_restart_pulse: assert property (
      s_restart_req |=> s_restart_pulse)
      else $error("restart pulse malformed");

   // Restart bit reads zero, no pulse without request
   chk_restart_sc: assert property (
      (ctrl_rd[CTRL_RESTART_BIT] == 1'b0) and (an_restart |-> $past(restart_go)))
      else $error("restart bit misbehaves");

   // Management pin driven low when read turnaround begins
   chk_mdio_ro_drive: assert property (
      $rose(mdio_oe) |-> (mdio_out == 1'b0))
      else $error("turnaround not driven low");

   // Advertisement write lands in pause bit
   chk_adv_pause_write: assert property (
      wr_adv |=> (adv_pause_r == $past(wr_data[ADV_PAUSE_BIT])))
      else $error("pause bit not stored");

   // Advertisement write lands in technology bits
   chk_adv_tech_write: assert property (
      wr_adv |=> (adv_tech_r == $past(wr_data[ADV_TECH_HI:ADV_TECH_LO])))
      else $error("technology bits not stored");

   // Advertisement word holds without a write
   chk_adv_hold: assert property (
      !wr_adv |=> $stable(adv_rd))
      else $error("advertise word changed without write");

   // Advertisement read shows each stored field
   chk_adv_read: assert property (
      (reg_addr == REG_ADV) |-> (rd_data[ADV_NP_BIT] == adv_np_r) && (rd_data[ADV_RF_BIT] == adv_rf_r)
      && (rd_data[ADV_PAUSE_BIT] == adv_pause_r) && (rd_data[ADV_TECH_HI:ADV_TECH_LO] == adv_tech_r) && (rd_data[4:0] == 5'h01))
      else $error("advertise read wrong");

   // Outgoing word back to defaults after reset
   chk_tx_reset_val: assert property (
      disable iff (1'b0)
      !resetn |=> (adv_tx_word == {6'h00, ADV_TECH_RST, ADV_SEL}))
      else $error("outgoing word reset value wrong");

   // Partner word empty after reset
   chk_lp_reset_val: assert property (
      disable iff (1'b0)
      !resetn |=> (lp_ability_r == LP_RST) && !lp_loaded_r)
      else $error("partner word not cleared by reset");

   // Restart wins over a page in the same cycle
   chk_lp_restart_wins: assert property (
      restart_go |=> (lp_ability_r == LP_RST))
      else $error("partner word kept over restart");

   // Loaded page still held after a following cycle with no page or restart
   chk_lp_load_order: assert property (
      s_page_settle |=> (lp_ability_r == $past(lp_page_word, 2)))
      else $error("partner page not kept");

   // Partner register reads the stored word
   chk_lp_read: assert property (
      (reg_addr == REG_LP) |-> (rd_data == lp_ability_r))
      else $error("partner read wrong");

   // Completion drops with the restart pulse
   chk_stat_restart: assert property (
      an_restart |-> !stat_rd[STAT_DONE_BIT])
      else $error("completion kept over restart");

   // Restart refused while negotiation is disabled
   chk_restart_refused: assert property (
      wr_ctrl && wr_data[CTRL_RESTART_BIT] && !(an_en_r && hw_en_s2) |=> !an_restart)
      else $error("restart taken while disabled");

   // Enable bit locked while the pin disables negotiation
   chk_ctrl_hw_lock: assert property (
      wr_ctrl && !hw_en_s2 |=> $stable(an_en_r))
      else $error("enable changed while pin low");

endmodule : anid_regs

// *** src/anid_pkg.sv ***
// Constants for the negotiation ability and identifier register bank.
// Assumes a single 125 MHz sys_clk domain and a serial management port.
package anid_pkg;

   // Management register addresses
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STAT = 5'h01;
   localparam logic [4:0] REG_ID_UP = 5'h02;
   localparam logic [4:0] REG_ID_LO = 5'h03;
   localparam logic [4:0] REG_ADV = 5'h04;
   localparam logic [4:0] REG_LP = 5'h05;

   // Control and status field positions
   localparam int CTRL_AN_EN_BIT = 12;
   localparam int CTRL_RESTART_BIT = 9;
   localparam int STAT_DONE_BIT = 5;
   localparam logic [15:0] STAT_FIXED = 16'h7809;
   localparam logic CTRL_AN_EN_RST = 1'h1;

   // Advertisement field positions and reset values
   localparam int ADV_NP_BIT = 15;
   localparam int ADV_RF_BIT = 13;
   localparam int ADV_PAUSE_BIT = 10;
   localparam int ADV_TECH_HI = 9;
   localparam int ADV_TECH_LO = 5;
   localparam logic [4:0] ADV_TECH_RST = 5'h05;
   localparam logic [4:0] ADV_SEL = 5'h01;
   localparam logic [15:0] LP_RST = 16'h0000;

   // Management frame fields
   localparam logic [5:0] PRE_ONES = 6'h20;
   localparam logic [5:0] OP_LAST = 6'h01;
   localparam logic [5:0] HDR_LAST = 6'h09;
   localparam logic [5:0] DATA_LAST = 6'h0F;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;

   // Management frame engine states
   typedef enum logic [2:0] {
      AS_PRE = 3'h0,
      AS_ST = 3'h1,
      AS_OP = 3'h2,
      AS_HDR = 3'h3,
      AS_TA = 3'h4,
      AS_DATA = 3'h5
   } anid_st_e;

endpackage : anid_pkg

// *** src/anid_mdio_ser.sv ***
// Serial management frame engine: preamble, start, opcode, addresses,
// turnaround and 16 data bits. Assumes mdc and mdio arrive from pins.
`timescale 1ns/10ps
module anid_mdio_ser
   import anid_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic mdc,
   input wire logic mdio_in,
   input wire logic [4:0] phy_addr,
   input wire logic [15:0] rd_data,
   output logic [4:0] reg_addr,
   output logic [15:0] wr_data,
   output logic wr_stb,
   output logic mdio_out,
   output logic mdio_oe
);

   anid_st_e state_r;
   logic mdc_s1, mdc_s2, mdc_s3;
   logic mdio_s1, mdio_s2;
   logic [4:0] pa_s1, pa_s2;
   logic [5:0] cnt_r;
   logic [1:0] op_r;
   logic [9:0] hdr_r;
   logic [15:0] shift_r;
   logic rd_go_r, wr_go_r;
   logic mdc_rise, bit_w, match_w;

   // Pin synchronisers; second stage sampled, third stage of mdc used for edge detection
   always_ff @(posedge sys_clk) begin
      mdc_s1 <= mdc;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
      pa_s1 <= phy_addr;
      pa_s2 <= pa_s1;
   end

   // Sampling point and address match
   assign mdc_rise = mdc_s2 & ~mdc_s3;
   assign bit_w = mdio_s2;
   assign match_w = (hdr_r[8:4] == pa_s2);
   assign reg_addr = hdr_r[4:0];

   // Frame sequencer; read data changes just after a clock rise
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_r <= AS_PRE;
         cnt_r <= 6'h00;
         op_r <= 2'h0;
         hdr_r <= 10'h000;
         shift_r <= 16'h0000;
         rd_go_r <= 1'b0;
         wr_go_r <= 1'b0;
         wr_data <= 16'h0000;
         wr_stb <= 1'b0;
         mdio_out <= 1'b0;
         mdio_oe <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         if (mdc_rise) begin
            unique case (state_r)
               AS_PRE: begin
                  if (bit_w) begin
                     if (cnt_r != PRE_ONES) cnt_r <= cnt_r + 6'h01;
                  end else if (cnt_r == PRE_ONES) begin
                     state_r <= AS_ST;
                  end else begin
                     cnt_r <= 6'h00;
                  end
               end
               AS_ST: begin
                  cnt_r <= 6'h00;
                  state_r <= bit_w ? AS_OP : AS_PRE;
               end
               AS_OP: begin
                  op_r <= {op_r[0], bit_w};
                  cnt_r <= (cnt_r == OP_LAST) ? 6'h00 : cnt_r + 6'h01;
                  if (cnt_r == OP_LAST) state_r <= AS_HDR;
               end
               AS_HDR: begin
                  hdr_r <= {hdr_r[8:0], bit_w};
                  cnt_r <= cnt_r + 6'h01;
                  if (cnt_r == HDR_LAST) begin
                     state_r <= AS_TA;
                     cnt_r <= 6'h00;
                     rd_go_r <= (op_r == OP_READ) && match_w;
                     wr_go_r <= (op_r == OP_WRITE) && match_w;
                  end
               end
               AS_TA: begin
                  cnt_r <= cnt_r + 6'h01;
                  if (cnt_r == 6'h00) begin
                     mdio_oe <= rd_go_r;
                     mdio_out <= 1'b0;
                     shift_r <= rd_data;
                  end else begin
                     state_r <= AS_DATA;
                     cnt_r <= 6'h00;
                     if (rd_go_r) begin
                        mdio_out <= shift_r[15];
                        shift_r <= {shift_r[14:0], 1'b0};
                     end
                  end
               end
               AS_DATA: begin
                  cnt_r <= cnt_r + 6'h01;
                  if (rd_go_r) begin
                     mdio_out <= shift_r[15];
                     shift_r <= {shift_r[14:0], 1'b0};
                  end else begin
                     shift_r <= {shift_r[14:0], bit_w};
                  end
                  if (cnt_r == DATA_LAST) begin
                     state_r <= AS_PRE;
                     cnt_r <= 6'h00;
                     mdio_oe <= 1'b0;
                     mdio_out <= 1'b0;
                     wr_stb <= wr_go_r;
                     wr_data <= {shift_r[14:0], bit_w};
                  end
               end
            endcase
         end
      end
   end

endmodule : anid_mdio_ser

// *** tb/anid_mgmt_model.sv ***
// Management station model: drives mdc and mdio frames from tasks.
// Assumes the bench resolves the mdio wire with a pull-up.
`timescale 1ns/10ps
module anid_mgmt_model
   import anid_pkg::*;
(
   input wire logic sys_clk,
   output logic mdc,
   output logic m_out,
   output logic m_oe,
   input wire logic mdio_wire
);
   // Clock idles low between frames, line released
   initial begin
      mdc = 1'b0;
      m_out = 1'b1;
      m_oe = 1'b0;
   end

   // One mdc period; data changes while mdc is low
   task automatic cyc(input logic b, input logic oe, output logic s);
      m_out = b;
      m_oe = oe;
      repeat (5) @(negedge sys_clk);
      mdc = 1'b1;
      s = mdio_wire;
      repeat (5) @(negedge sys_clk);
      mdc = 1'b0;
   endtask : cyc

   // Whole frame: preamble, start, op, addresses, turnaround, data
   task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] wd, input int pre, output logic [15:0] rd);
      logic [31:0] w;
      logic s;
      w = {2'b01, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      repeat (pre) cyc(1'b1, 1'b1, s);
      for (int i = 31; i >= 0; i--) begin
         cyc(w[i], !(op == OP_READ && i < 18), s);
         if (i < 16) rd[i] = s;
      end
      m_oe = 1'b0;
      @(negedge sys_clk); // Released line stands before the next frame
   endtask : frame
endmodule : anid_mgmt_model

// *** tb/anid_regs_tb_top.sv ***
// Testbench for the identifier and negotiation register bank.
// Assumes the management model above and a pull-up on mdio.
`timescale 1ns/10ps
module anid_regs_tb_top;
   import anid_pkg::*;
   localparam logic [23:0] T_OUI = 24'hC3A5E1; // Arbitrary value
   localparam logic [5:0] T_MODEL = 6'h15; // Arbitrary value
   localparam logic [3:0] T_REV = 4'h9; // Arbitrary value
   localparam logic [4:0] PA = 5'h03;
   localparam logic [15:0] ADV_MASK = 16'hA7FF;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic an_hw_en = 1'b1;
   logic an_complete = 1'b0;
   logic lp_page_stb = 1'b0;
   logic [15:0] lp_page_word = 16'h0000;
   logic [4:0] phy_addr = PA;
   logic mdc, m_out, m_oe, mdio_out, mdio_oe, an_restart;
   logic [15:0] adv_tx_word, rd;
   wire logic mdio_wire;
   int err_count = 0;
   int check_count = 0;
   int cyc_count = 0;
   int rst_pulses = 0;

   // Pin level: device, then master, else pull-up
   assign mdio_wire = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);
   always #4 sys_clk = ~sys_clk;

   // Cycle ceiling and restart pulse tally
   always @(posedge sys_clk) begin
      cyc_count <= cyc_count + 1;
      if (an_restart === 1'b1) rst_pulses <= rst_pulses + 1;
      if (cyc_count == 60000) begin
         err_count++;
         summarize();
      end
   end

   anid_regs #(.OUI(T_OUI), .MODEL(T_MODEL), .REVISION(T_REV)) dut (
      .sys_clk(sys_clk), .resetn(resetn), .mdc(mdc), .mdio_in(mdio_wire),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr(phy_addr),
      .an_hw_en(an_hw_en), .an_complete(an_complete), .lp_page_stb(lp_page_stb),
      .lp_page_word(lp_page_word), .adv_tx_word(adv_tx_word), .an_restart(an_restart));

   anid_mgmt_model mgmt (.sys_clk(sys_clk), .mdc(mdc), .m_out(m_out), .m_oe(m_oe), .mdio_wire(mdio_wire));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] x;
      mgmt.frame(OP_WRITE, PA, ra, d, 32, x);
   endtask : wr

   task automatic rdr(input logic [4:0] ra, output logic [15:0] d);
      mgmt.frame(OP_READ, PA, ra, 16'h0000, 32, d);
   endtask : rdr

   task automatic do_reset();
      @(negedge sys_clk);
      resetn = 1'b0;
      repeat (3) @(negedge sys_clk);
      resetn = 1'b1;
   endtask : do_reset

   // Defaults after reset, completion held off without a page
   task automatic t_reset();
      an_complete = 1'b1;
      check(adv_tx_word & ADV_MASK, 16'h00A1);
      rdr(REG_ADV, rd);
      check(rd & ADV_MASK, 16'h00A1);
      rdr(REG_LP, rd);
      check(rd, 16'h0000);
      rdr(REG_STAT, rd);
      check(rd & 16'h0020, 16'h0000);
   endtask : t_reset

   // Identifier words, and writes to them refused
   task automatic t_ident();
      rdr(REG_ID_UP, rd);
      check(rd, T_OUI[21:6]);
      rdr(REG_ID_LO, rd);
      check(rd, {T_OUI[5:0], T_MODEL, T_REV});
      wr(REG_ID_UP, 16'h0000);
      wr(REG_ID_LO, 16'hFFFF);
      rdr(REG_ID_UP, rd);
      check(rd, T_OUI[21:6]);
      rdr(REG_ID_LO, rd);
      check(rd, {T_OUI[5:0], T_MODEL, T_REV});
   endtask : t_ident

   // Each writable advertisement bit alone, then all ones
   task automatic t_adv();
      int bits [8] = '{15, 13, 10, 9, 8, 7, 6, 5};
      logic [15:0] v;
      foreach (bits[k]) begin
         v = 16'h0001 << bits[k];
         wr(REG_ADV, v);
         rdr(REG_ADV, rd);
         check(rd & ADV_MASK, v | 16'h0001);
         check(adv_tx_word & ADV_MASK, v | 16'h0001);
      end
      wr(REG_ADV, 16'hFFFE);
      rdr(REG_ADV, rd);
      check(rd & ADV_MASK, 16'hA7E1);
   endtask : t_adv

   // Received page, then restart clears it
   task automatic t_partner();
      int n;
      @(negedge sys_clk);
      lp_page_word = 16'hE5E1;
      lp_page_stb = 1'b1;
      @(negedge sys_clk);
      lp_page_stb = 1'b0;
      lp_page_word = 16'h1A1E;
      rdr(REG_STAT, rd);
      check(rd & 16'h0020, 16'h0020);
      rdr(REG_LP, rd);
      check(rd & 16'hE7FF, 16'hE5E1);
      n = rst_pulses;
      wr(REG_CTRL, 16'h1200);
      check(16'(rst_pulses - n), 16'h0001);
      rdr(REG_CTRL, rd);
      check(rd & 16'h0200, 16'h0000);
      rdr(REG_LP, rd);
      check(rd, 16'h0000);
      rdr(REG_STAT, rd);
      check(rd & 16'h0020, 16'h0000);
   endtask : t_partner

   // Foreign address, short preamble, restart with pin low
   task automatic t_refuse();
      int n;
      mgmt.frame(OP_WRITE, PA ^ 5'h01, REG_ADV, 16'h0000, 32, rd);
      mgmt.frame(OP_WRITE, PA, REG_ADV, 16'h0000, 20, rd);
      rdr(REG_ADV, rd);
      check(rd & ADV_MASK, 16'hA7E1);
      an_hw_en = 1'b0;
      n = rst_pulses;
      wr(REG_CTRL, 16'h1200);
      check(16'(rst_pulses - n), 16'h0000);
      an_hw_en = 1'b1;
      wr(REG_CTRL, 16'h0000);
      rdr(REG_CTRL, rd);
      check(rd & 16'h1000, 16'h0000);
      n = rst_pulses;
      wr(REG_CTRL, 16'h0200);
      check(16'(rst_pulses - n), 16'h0000);
      wr(REG_CTRL, 16'h1000);
   endtask : t_refuse

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize

   // Main sequence, with a second reset mid-run
   initial begin
      do_reset();
      t_reset();
      t_ident();
      t_adv();
      t_partner();
      t_refuse();
      do_reset();
      t_reset();
      summarize();
   end
endmodule : anid_regs_tb_top
